// >>> src/tpg_params.svh
// constants of the test-pattern control block: register indices, fields, resets
// assumes byte address = 4 * index on a 32-bit bus
`ifndef TPG_PARAMS_SVH
`define TPG_PARAMS_SVH
`define SEL_IDX 8'h64
`define CFG_IDX 8'h65
`define IA_IDX 8'h66
`define ID_IDX 8'h67
`define CFG_RESET 8'h00
`define IA_RESET 8'h00
`define SEL_RESET 3'h0
`define CFG_CYCLE_BIT 0
`define CFG_INVERT_BIT 1
`define CFG_TIMSEL_BIT 2
`define CFG_BPP18_BIT 4
`define CFG_CUSTOM_BIT 5
`define CFG_SCALE_BIT 6
`define CFG_MASK 8'h77
`define IND_PAT_ENABLE 8'h00
`define IND_FRAME_DWELL 8'h01
`define IND_HTOT_LO 8'h02
`define IND_HTOT_HI 8'h03
`define IND_VTOT_LO 8'h04
`define IND_VTOT_HI 8'h05
`define IND_HACT_LO 8'h06
`define IND_HACT_HI 8'h07
`define IND_VACT_LO 8'h08
`define IND_VACT_HI 8'h09
`define IND_HSW 8'h0a
`define IND_VSW 8'h0b
`define IND_HBP 8'h0c
`define IND_VBP 8'h0d
`define IND_SYNC_CFG 8'h0e
`define IND_RESET 8'h00
`define PIX_W 27
`define BUF_DEPTH 2
`endif

// >>> src/tpg_pkg.sv
// types shared by the test-pattern control block
// assumes tpg_params.svh for numeric constants
`default_nettype none
package tpg_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [11:0] count_t;
    typedef logic [23:0] color_t;
    typedef enum logic {SRC_EXTERNAL, SRC_INTERNAL} timing_src_e;
endpackage : tpg_pkg
`default_nettype wire

// >>> src/test_pattern_control.sv
// test-pattern control: timing source choice, colour invert, pattern cycling,
// indirect register window, two-entry output buffer, AHB-Lite register slave.
// assumes a single AHB-Lite master and a pattern engine feeding pat_color.
`include "tpg_params.svh"
`default_nettype none
module test_pattern_control (
    input wire logic clk, // 125 MHz
    input wire logic rst_b, // async reset
    input wire logic ce, // freezes all state when low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // word only
    input wire logic hready, // bus ready
    input wire logic [31:0] hwdata, // write data
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic ext_valid, // external pixel beat
    output logic ext_ready, // external beat taken
    input wire logic ext_de, // external data enable
    input wire logic ext_hs, // external hsync
    input wire logic ext_vs, // external vsync
    input wire tpg_pkg::color_t pat_color, // pattern engine colour
    output logic [2:0] pat_index, // current pattern
    output logic cfg_checker_scale, // to pattern engine
    output logic cfg_custom_checker, // to pattern engine
    output logic cfg_bpp18, // to pattern engine
    output logic pix_valid, // output beat valid
    input wire logic pix_ready, // receiver ready
    output logic pix_de, // output data enable
    output logic pix_hs, // output hsync
    output logic pix_vs, // output vsync
    output tpg_pkg::color_t pix_color // output colour
);
    import tpg_pkg::*;

    byte_t cfg_q;
    byte_t ia_q;
    byte_t ind_mem [256];
    logic [2:0] pat_q;
    byte_t frame_cnt_q;
    count_t h_q;
    count_t v_q;
    logic vs_prev_q;
    logic wr_pend_q;
    logic [7:0] wr_idx_q;
    logic [31:0] hrdata_q;

    // bus decode
    wire addr_hit = hsel && htrans[1] && hready && (haddr[31:10] == 22'h00_0000);
    wire rd_take = addr_hit && !hwrite && ce;
    wire wr_take = addr_hit && hwrite && ce;
    wire [7:0] rd_idx = haddr[9:2];
    wire wr_now = wr_pend_q && ce;
    wire wr_cfg = wr_now && (wr_idx_q == `CFG_IDX);
    wire wr_ia = wr_now && (wr_idx_q == `IA_IDX);
    wire wr_id = wr_now && (wr_idx_q == `ID_IDX);
    wire wr_sel = wr_now && (wr_idx_q == `SEL_IDX);
    wire [7:0] wdata = hwdata[7:0];

    // read mux; unmapped words read zero
    wire [7:0] rd_byte =
        (rd_idx == `CFG_IDX) ? cfg_q :
        (rd_idx == `IA_IDX) ? ia_q :
        (rd_idx == `ID_IDX) ? ind_mem[ia_q] :
        (rd_idx == `SEL_IDX) ? {5'h00, pat_q} : 8'h00;

    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // configuration fields
    wire cycle_en = cfg_q[`CFG_CYCLE_BIT];
    wire invert = cfg_q[`CFG_INVERT_BIT];
    timing_src_e tim_src;
    assign tim_src = cfg_q[`CFG_TIMSEL_BIT] ? SRC_INTERNAL : SRC_EXTERNAL;
    assign cfg_checker_scale = cfg_q[`CFG_SCALE_BIT];
    assign cfg_custom_checker = cfg_q[`CFG_CUSTOM_BIT];
    assign cfg_bpp18 = cfg_q[`CFG_BPP18_BIT];
    assign pat_index = pat_q;

    // indirect timing set
    wire count_t htot = {ind_mem[`IND_HTOT_HI][3:0], ind_mem[`IND_HTOT_LO]};
    wire count_t vtot = {ind_mem[`IND_VTOT_HI][3:0], ind_mem[`IND_VTOT_LO]};
    wire count_t hact = {ind_mem[`IND_HACT_HI][3:0], ind_mem[`IND_HACT_LO]};
    wire count_t vact = {ind_mem[`IND_VACT_HI][3:0], ind_mem[`IND_VACT_LO]};
    wire count_t hsw = {4'h0, ind_mem[`IND_HSW]};
    wire count_t vsw = {4'h0, ind_mem[`IND_VSW]};
    wire count_t hbp = {4'h0, ind_mem[`IND_HBP]};
    wire count_t vbp = {4'h0, ind_mem[`IND_VBP]};
    wire byte_t sync_cfg = ind_mem[`IND_SYNC_CFG];
    wire byte_t pat_mask = ind_mem[`IND_PAT_ENABLE];
    wire byte_t dwell = ind_mem[`IND_FRAME_DWELL];

    // internal timing: sync pulse sits just before back porch at line/frame end
    wire count_t hs_end = htot - hbp;
    wire count_t hs_beg = hs_end - hsw;
    wire count_t vs_end = vtot - vbp;
    wire count_t vs_beg = vs_end - vsw;
    wire h_last = (h_q + 12'h001) >= htot;
    wire v_last = (v_q + 12'h001) >= vtot;
    wire int_de = (h_q < hact) && (v_q < vact);
    wire int_hs = ((h_q >= hs_beg) && (h_q < hs_end)) ^ sync_cfg[0];
    wire int_vs = ((v_q >= vs_beg) && (v_q < vs_end)) ^ sync_cfg[1];

    // source selection
    wire src_int = (tim_src == SRC_INTERNAL);
    wire src_valid = src_int ? 1'b1 : ext_valid;
    wire src_de = src_int ? int_de : ext_de;
    wire src_hs = src_int ? int_hs : ext_hs;
    wire src_vs = src_int ? int_vs : ext_vs;
    wire color_t src_color = invert ? ~pat_color : pat_color;

    // output buffer
    logic [1:0] buf_cnt_q;
    logic buf_wp_q;
    logic buf_rp_q;
    logic [`PIX_W-1:0] buf_mem_q [`BUF_DEPTH];
    wire buf_full = (buf_cnt_q == 2'd2);
    wire push = src_valid && !buf_full && ce;
    wire pop = pix_valid && pix_ready && ce;
    wire [`PIX_W-1:0] push_word = {src_de, src_hs, src_vs, src_color};
    wire [`PIX_W-1:0] head = buf_mem_q[buf_rp_q];

    // internal source is dropped-in when selected; external beats drain when unused
    assign ext_ready = src_int ? ce : (!buf_full && ce);
    assign pix_valid = (buf_cnt_q != 2'd0);
    assign pix_de = head[26];
    assign pix_hs = head[25];
    assign pix_vs = head[24];
    assign pix_color = head[23:0];

    generate
        for (genvar e = 0; e < `BUF_DEPTH; e++) begin : g_buf
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    buf_mem_q[e] <= 27'h000_0000;
                end else if (push && (buf_wp_q == 1'(e))) begin
                    buf_mem_q[e] <= push_word;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            buf_cnt_q <= 2'd0;
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
        end else begin
            buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
            buf_wp_q <= buf_wp_q ^ push;
            buf_rp_q <= buf_rp_q ^ pop;
        end
    end

    // internal counters advance only when the beat is buffered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            h_q <= 12'h000;
            v_q <= 12'h000;
        end else if (push && src_int) begin
            h_q <= h_last ? 12'h000 : h_q + 12'h001;
            if (h_last) begin
                v_q <= v_last ? 12'h000 : v_q + 12'h001;
            end
        end
    end

    // frame start of whichever source is active; external vsync assumed active high
    wire frame_start = push && (src_int ? (h_q == 12'h000 && v_q == 12'h000)
                                        : (ext_vs && !vs_prev_q));
    wire byte_t dwell_eff = (dwell == 8'h00) ? 8'h01 : dwell;
    wire advance = cycle_en && frame_start && ((frame_cnt_q + 8'h01) >= dwell_eff);

    function automatic logic [2:0] next_pattern(input logic [2:0] cur, input byte_t mask);
        logic [2:0] cand;
        logic [2:0] res;
        res = cur;
        for (int i = 7; i >= 1; i--) begin
            cand = cur + 3'(i);
            if (mask[cand]) begin
                res = cand;
            end
        end
        return res;
    endfunction : next_pattern

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vs_prev_q <= 1'b0;
        end else if (push && !src_int) begin
            vs_prev_q <= ext_vs;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_cnt_q <= 8'h00;
        end else if (ce) begin
            if (!cycle_en || advance) begin
                frame_cnt_q <= 8'h00;
            end else if (frame_start) begin
                frame_cnt_q <= frame_cnt_q + 8'h01;
            end
        end
    end

    // a software write of the pattern select beats a same-cycle advance
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pat_q <= `SEL_RESET;
        end else if (wr_sel) begin
            pat_q <= wdata[2:0];
        end else if (advance) begin
            pat_q <= next_pattern(pat_q, pat_mask);
        end
    end

    // register slave: address phase captured, write done in data phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else if (ce) begin
            wr_pend_q <= wr_take;
            wr_idx_q <= haddr[9:2];
            if (rd_take) begin
                hrdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= `CFG_RESET;
            ia_q <= `IA_RESET;
        end else begin
            if (wr_cfg) begin
                cfg_q <= wdata & `CFG_MASK;
            end
            if (wr_ia) begin
                ia_q <= wdata;
            end
        end
    end

    // indirect registers; software is expected to set the address first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < 256; k++) begin
                ind_mem[k] <= `IND_RESET;
            end
        end else if (wr_id) begin
            ind_mem[ia_q] <= wdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_lone_push;
        push && (buf_cnt_q == 2'd0);
    endsequence

    sequence s_frame_hold;
        !cycle_en && !wr_sel;
    endsequence

    // one internally timed beat entering the buffer
    sequence s_int_push;
        push && src_int;
    endsequence

    a_ext_timing_pass: assert property (s_lone_push ##0 !src_int |=>
        pix_valid && pix_de == $past(ext_de) && pix_vs == $past(ext_vs))
        else $error("external timing not passed through");
    a_int_line_wrap: assert property (push && src_int && h_last |=> h_q == 12'h000)
        else $error("internal line counter did not wrap");
    a_color_invert: assert property (s_lone_push ##0 invert |=>
        pix_color == ~$past(pat_color))
        else $error("colour not inverted");
    a_color_plain: assert property (s_lone_push ##0 !invert |=>
        pix_color == $past(pat_color))
        else $error("colour changed while invert off");
    a_pattern_hold: assert property (s_frame_hold |=> $stable(pat_q))
        else $error("pattern moved with cycling off");
    a_pattern_step: assert property (advance && !wr_sel |=>
        pat_q == next_pattern($past(pat_q), $past(pat_mask)))
        else $error("pattern did not advance to next enabled");
    a_ia_write: assert property (wr_ia |=> ia_q == $past(wdata))
        else $error("indirect address not stored");
    a_id_write: assert property (wr_id |=> ind_mem[$past(ia_q)] == $past(wdata))
        else $error("indirect data not delivered");
    a_id_read: assert property (rd_take && rd_idx == `ID_IDX && !wr_now |=>
        hrdata_q == {24'h00_0000, ind_mem[$past(ia_q)]})
        else $error("indirect read returned wrong value");
    a_count_clear: assert property (ce && (!cycle_en || advance) |=> frame_cnt_q == 8'h00)
        else $error("frame counter not restarted");
    a_buf_bound: assert property (buf_cnt_q <= 2'd2 && !(buf_full && push))
        else $error("buffer overfilled");

    // clock enable low is a stall: nothing may move, the bus included
    a_freeze_state: assert property (!ce |=> $stable(cfg_q) && $stable(pat_q)
        && $stable(buf_cnt_q) && $stable(h_q) && $stable(frame_cnt_q))
        else $error("state moved while clock enable low");
    a_ext_ready_full: assert property (!src_int && buf_full |-> !ext_ready)
        else $error("external beat offered room while buffer full");
    a_int_frame_wrap: assert property (s_int_push ##0 (h_last && v_last) |=>
        h_q == 12'h000 && v_q == 12'h000)
        else $error("internal frame counter did not wrap");
    a_int_de_window: assert property (s_lone_push ##0 src_int |=>
        pix_de == ($past(h_q) < $past(hact) && $past(v_q) < $past(vact)))
        else $error("internal data enable outside active window");
    a_pix_stall: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_color))
        else $error("stalled output beat changed");
    a_next_enabled: assert property (advance && !wr_sel && !wr_id
        && pat_mask != 8'h00 |=> pat_mask[pat_q])
        else $error("advanced to a disabled pattern");
    a_count_step: assert property (ce && cycle_en && frame_start && !advance |=>
        frame_cnt_q == $past(frame_cnt_q) + 8'h01)
        else $error("frame counter missed a frame start");
    a_sel_write: assert property (wr_sel |=> pat_q == $past(wdata[2:0]))
        else $error("pattern select not stored");
    a_cfg_write: assert property (wr_cfg |=> cfg_q == ($past(wdata) & `CFG_MASK))
        else $error("configuration not stored");
    a_rd_upper_zero: assert property (hrdata_q[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
endmodule : test_pattern_control
`default_nettype wire

// >>> dv/test_pattern_control_bench.sv
// bench for test_pattern_control: registers over AHB-Lite, pixel stream, cycling
// assumes tpg_params.svh and tpg_pkg from src/, zero wait states while ce is high
`include "tpg_params.svh"
`default_nettype none
module test_pattern_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tpg_pkg::*;
    logic clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, ext_valid, ext_ready;
    logic ext_de, ext_hs, ext_vs, pix_ready, pix_valid, pix_de, pix_hs, pix_vs;
    logic cfg_checker_scale, cfg_custom_checker, cfg_bpp18, ce;
    logic [1:0] htrans;
    logic [2:0] pat_index;
    logic [31:0] haddr, hwdata, hrdata;
    color_t pat_color, pix_color;
    int err_total, comparisons, cyc;
    assign hready = hreadyout;
    test_pattern_control test_pattern_control_i (.clk(clk), .rst_b(rst_b), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_valid(ext_valid), .ext_ready(ext_ready), .ext_de(ext_de),
        .ext_hs(ext_hs), .ext_vs(ext_vs), .pat_color(pat_color), .pat_index(pat_index),
        .cfg_checker_scale(cfg_checker_scale), .cfg_custom_checker(cfg_custom_checker),
        .cfg_bpp18(cfg_bpp18), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_de(pix_de), .pix_hs(pix_hs), .pix_vs(pix_vs), .pix_color(pix_color));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // no master-side assumption on latency: wait for hready, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            $display("Error bus wait timed out");
            err_total++;
            finish_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, idx, {24'h0, d}, r);
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, idx, 32'h0000_0000, r);
        chk(what, {24'h0, e}, r);
    endtask : rd_chk
    task automatic ind(input logic [7:0] a, input logic [7:0] d);
        wr(`IA_IDX, a);
        wr(`ID_IDX, d);
    endtask : ind
    task automatic t_reset();
        rd_chk("ind_addr", `IA_IDX, 8'h00);
        rd_chk("cfg", `CFG_IDX, 8'h00);
        rd_chk("sel", `SEL_IDX, 8'h00);
        rd_chk("ind_data", `ID_IDX, 8'h00);
        wr(8'h68, 8'h55);
        rd_chk("unmapped", 8'h68, 8'h00);
        wr(`IA_IDX, 8'hff);
        rd_chk("ind_addr_rw", `IA_IDX, 8'hff);
    endtask : t_reset
    task automatic t_indirect();
        ind(8'h0c, 8'h5a);
        ind(8'h0d, 8'ha5);
        wr(`IA_IDX, 8'h0c);
        rd_chk("ind_hbp", `ID_IDX, 8'h5a);
        wr(`IA_IDX, 8'h0d);
        rd_chk("ind_vbp", `ID_IDX, 8'ha5);
    endtask : t_indirect
    // two beats into the two-entry buffer with the receiver stalled, then drain
    task automatic t_stream(input logic [7:0] cv);
        color_t c0, c1;
        c0 = 24'h12_3456;
        c1 = 24'h00_ff00;
        wr(`CFG_IDX, cv);
        rd_chk("cfg_rb", `CFG_IDX, cv & `CFG_MASK);
        chk("cfg_out", {29'h0, cv[6:4]},
            {29'h0, cfg_checker_scale, cfg_custom_checker, cfg_bpp18});
        pix_ready <= 1'b0;
        ext_valid <= 1'b1;
        ext_de <= 1'b1;
        ext_hs <= 1'b1;
        pat_color <= c0;
        @(posedge clk);
        ext_de <= 1'b0;
        ext_hs <= 1'b0;
        ext_vs <= 1'b1;
        pat_color <= c1;
        @(posedge clk);
        ext_valid <= 1'b0;
        ext_vs <= 1'b0;
        #1;
        chk("ext_ready_full", 32'h0, {31'h0, ext_ready});
        chk("beat0", {8'h0, cv[1] ? ~c0 : c0}, {8'h0, pix_color});
        chk("beat0_sync", 32'h6, {29'h0, pix_de, pix_hs, pix_vs});
        @(posedge clk);
        pix_ready <= 1'b1;
        @(posedge clk);
        #1;
        chk("beat1", {8'h0, cv[1] ? ~c1 : c1}, {8'h0, pix_color});
        chk("beat1_sync", 32'h1, {29'h0, pix_de, pix_hs, pix_vs});
        @(posedge clk);
        #1;
        chk("drained", 32'h0, {31'h0, pix_valid});
    endtask : t_stream
    // 4x2 frame, 2x1 active, one-pixel hsync: 2 de and 2 hs beats per 8
    task automatic t_internal();
        int n, de_n, hs_n, k;
        ind(`IND_HTOT_LO, 8'h04);
        ind(`IND_VTOT_LO, 8'h02);
        ind(`IND_HACT_LO, 8'h02);
        ind(`IND_VACT_LO, 8'h01);
        ind(`IND_HSW, 8'h01);
        ind(`IND_HBP, 8'h01);
        wr(`CFG_IDX, 8'h04);
        n = 0; de_n = 0; hs_n = 0; k = 0;
        while (n < 8 && k < 60) begin
            @(posedge clk);
            #1;
            k++;
            if (pix_valid === 1'b1) begin
                n++;
                de_n += pix_de;
                hs_n += pix_hs;
            end
        end
        chk("int_beats", 32'd8, n);
        chk("int_de", 32'd2, de_n);
        chk("int_hs", 32'd2, hs_n);
        chk("int_ext_ready", 32'h1, {31'h0, ext_ready});
    endtask : t_internal
    // mask 0,1,3 with dwell 2: expect 1,3,0, sixteen beats apart
    task automatic t_cycle();
        int t[3], p[3], n, k;
        logic [2:0] last;
        ind(`IND_PAT_ENABLE, 8'h0b);
        ind(`IND_FRAME_DWELL, 8'h02);
        wr(`SEL_IDX, 8'h00);
        wr(`CFG_IDX, 8'h05);
        last = pat_index;
        n = 0;
        k = 0;
        while (n < 3 && k < 300) begin
            @(posedge clk);
            #1;
            k++;
            if (pat_index !== last) begin
                p[n] = pat_index;
                t[n] = cyc;
                n++;
                last = pat_index;
            end
        end
        chk("adv_count", 32'd3, n);
        chk("adv_seq", 32'h0130, {20'h0, p[0][3:0], p[1][3:0], p[2][3:0]});
        chk("dwell_a", 32'd16, t[1] - t[0]);
        chk("dwell_b", 32'd16, t[2] - t[1]);
        wr(`CFG_IDX, 8'h04);
        last = pat_index;
        n = 0;
        repeat (80) begin
            @(posedge clk);
            #1;
            if (pat_index !== last) n++;
        end
        chk("held", 32'd0, n);
        wr(`SEL_IDX, 8'h02);
        rd_chk("sel_rb", `SEL_IDX, 8'h02);
    endtask : t_cycle
    // clock enable low: outputs and state hold, the bus inserts wait states
    task automatic t_freeze();
        logic [26:0] held;
        fork
            begin
                ce <= 1'b0;
                @(posedge clk);
                #1;
                held = {pix_de, pix_hs, pix_vs, pix_color};
                chk("frozen_ready", 32'h0, {31'h0, hreadyout});
                repeat (3) @(posedge clk);
                ce <= 1'b1;
                #1;
                chk("frozen_beat", {5'h0, held}, {5'h0, pix_de, pix_hs, pix_vs, pix_color});
            end
            rd_chk("sel_waited", `SEL_IDX, 8'h02);
        join
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : t_freeze
    initial begin
        {rst_b, hsel, hwrite, ext_valid, ext_de, ext_hs, ext_vs, pix_ready} = '0;
        {htrans, haddr, hwdata, pat_color} = '0;
        err_total = 0;
        comparisons = 0;
        ce = 1'b1;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_indirect();
        t_stream(8'h00);
        t_stream(8'hfa);
        t_internal();
        t_cycle();
        t_freeze();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        $display("Error run timed out");
        err_total++;
        finish_test();
    end
endmodule : test_pattern_control_bench
`default_nettype wire
